// file: src/tfq_ctrl.sv
// Transmit queue host write control, reset, halt, self-test and full flag
// Contract
// - Writes only when selected and enabled, per edge
// - Selected means enable after chip select low
// - Mode low: enable active low, same-cycle capture
// - Mode high: enable active high, next-cycle capture
// - Self-test sends repeating 511-character sequence
// - Self-test suspends queue reads until released
// - Queue reset needs seven qualified low samples
// - Reset sets full, clears host then serial
// - Held reset request keeps queue and full
// - Bypassed queue ignores reset request entirely
// - Halt low sends fill characters instead
// - Halt does not block host writes
// - Full when four or fewer places free
// - Full held asserted during queue reset
// - Bypassed: full tracks busy, reference edges
// - Bypassed double rate: full toggles per character
// - Full polarity follows the mode input
// - Data sampled on queue or reference edge
`timescale 1ns/10ps
`default_nettype none
module tfq_ctrl
  import tfq_pkg::*;
#(
  parameter int DEPTH = TFQ_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_queue_clock,
  input wire logic reference_clock,
  input wire logic chip_select_n,
  input wire logic tx_write_enable,
  input wire logic external_queue_mode_sel,
  input wire logic tx_selftest_enable_n,
  input wire logic tx_queue_reset_req,
  input wire logic tx_suspend_n,
  input wire logic queue_bypass_sel,
  input wire logic freq_range_sel,
  input wire logic speed_sel,
  input wire logic [TFQ_DATA_W-1:0] tx_parallel_word,
  output logic tx_queue_full_flag,
  output logic tx_queue_full_flag_oe,
  output tfq_char_t tx_char,
  output logic selftest_loop_end
);

  localparam logic [AW:0] LVL_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] LVL_NEAR = (AW+1)'(DEPTH - TFQ_FULL_MARGIN);

  typedef struct packed {
    tfq_pins_t s1;
    tfq_pins_t s2;
    logic tclk_d;
    logic rclk_d;
    logic sel_prev;
    logic pend;
    logic halt;
    logic [2:0] rcnt;
    tfq_rst_t rst_st;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic rd_pend;
    logic ref_phase;
    logic char_tgl;
    logic hold_v;
    logic [TFQ_DATA_W-1:0] hold_w;
    logic [8:0] lfsr;
    logic [8:0] st_cnt;
    logic seq_end;
    tfq_char_t ch;
    logic full_pin;
    logic full_oe;
  } tfq_state_t;

  tfq_state_t st_r;
  tfq_state_t st_nxt;

  logic tx_rise;
  logic ref_rise;
  logic bypassed;
  logic mode_hi;
  logic host_edge;
  logic fast;
  logic slot;
  logic selftest;
  logic wen_act;
  logic rst_cond;
  logic in_reset;
  logic [AW:0] level;
  logic room;
  logic near_full;
  logic full_act;
  logic wr_req;
  logic [TFQ_DATA_W-1:0] wr_word;
  logic mem_we;
  logic rd_issue;
  logic [TFQ_DATA_W-1:0] mem_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Decoded views of the synchronised pins
  assign tx_rise = st_r.s2.tx_queue_clock & ~st_r.tclk_d;
  assign ref_rise = st_r.s2.reference_clock & ~st_r.rclk_d;
  assign bypassed = ~st_r.s2.queue_bypass_sel;
  assign mode_hi = st_r.s2.external_queue_mode_sel;
  // Host side runs off the reference edge once the queue is bypassed
  assign host_edge = bypassed ? ref_rise : tx_rise;
  assign fast = st_r.s2.freq_range_sel | ~st_r.s2.speed_sel;
  assign slot = ref_rise & (~fast | st_r.ref_phase);
  assign selftest = ~st_r.s2.tx_selftest_enable_n;
  assign wen_act = mode_hi ? st_r.s2.tx_write_enable
                           : ~st_r.s2.tx_write_enable;
  assign rst_cond = ~bypassed & ~wen_act & ~st_r.s2.chip_select_n
                  & ~st_r.s2.tx_queue_reset_req;
  assign in_reset = st_r.rst_st != TFQ_RUN;
  assign level = st_r.wptr - st_r.rptr;
  assign room = level != LVL_FULL;
  assign near_full = level >= LVL_NEAR;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    wr_req = 1'b0;
    wr_word = st_r.s2.tx_parallel_word;
    mem_we = 1'b0;
    rd_issue = 1'b0;
    full_act = 1'b0;
    // Two flops on every pin, then edge history of the clocks
    st_nxt.s1 = '{tx_queue_clock, reference_clock, chip_select_n,
                  tx_write_enable, external_queue_mode_sel,
                  tx_selftest_enable_n, tx_queue_reset_req, tx_suspend_n,
                  queue_bypass_sel, freq_range_sel, speed_sel,
                  tx_parallel_word};
    st_nxt.s2 = st_r.s1;
    st_nxt.tclk_d = st_r.s2.tx_queue_clock;
    st_nxt.rclk_d = st_r.s2.reference_clock;
    st_nxt.ch.valid = 1'b0;
    st_nxt.seq_end = 1'b0;

    // Halt is only looked at on queue clock edges
    if (tx_rise) begin
      st_nxt.halt = ~st_r.s2.tx_suspend_n;
    end

    // Host write decode; selection needs chip select on the prior edge
    if (host_edge) begin
      st_nxt.sel_prev = ~st_r.s2.chip_select_n;
      if (mode_hi) begin
        // Enable seen now, data taken on the following edge
        st_nxt.pend = wen_act & st_r.sel_prev;
        wr_req = st_r.pend;
      end else begin
        st_nxt.pend = 1'b0;
        wr_req = wen_act & st_r.sel_prev;
      end
    end

    // Count qualified reset samples; any gap starts over
    if (tx_rise) begin
      if (!rst_cond) begin
        st_nxt.rcnt = '0;
      end else if (st_r.rcnt != TFQ_RST_CNT_MAX) begin
        st_nxt.rcnt = st_r.rcnt + 3'h1;
      end
    end

    // Reset sequencing: host side, then serial side, then hold
    case (st_r.rst_st)
      TFQ_RUN: begin
        if (st_nxt.rcnt == TFQ_RST_CNT_MAX && tx_rise) begin
          st_nxt.rst_st = TFQ_RST_HOST;
          wr_req = 1'b0;
        end
      end
      TFQ_RST_HOST: begin
        st_nxt.wptr = '0;
        st_nxt.rst_st = TFQ_RST_SERIAL;
      end
      TFQ_RST_SERIAL: begin
        // Serial side pointers follow on its own reference edge
        if (ref_rise) begin
          st_nxt.rptr = '0;
          st_nxt.rd_pend = 1'b0;
          st_nxt.rst_st = TFQ_RST_HOLD;
        end
      end
      TFQ_RST_HOLD: begin
        if (tx_rise && st_r.s2.tx_queue_reset_req) begin
          st_nxt.rst_st = TFQ_RUN;
        end
      end
      default: begin
        st_nxt.rst_st = TFQ_RUN;
      end
    endcase

    // Route a write: holding register when bypassed, else the queue
    if (wr_req) begin
      if (bypassed) begin
        if (!st_r.hold_v) begin
          st_nxt.hold_v = 1'b1;
          st_nxt.hold_w = wr_word;
        end
      end else if (room && !in_reset) begin
        mem_we = 1'b1;
        st_nxt.wptr = st_r.wptr + 1'b1;
      end
    end

    // Character pacing; double-rate reference takes two edges
    if (ref_rise) begin
      st_nxt.ref_phase = fast ? ~st_r.ref_phase : 1'b0;
    end

    // Data from a read issued last cycle goes out now
    if (st_r.rd_pend) begin
      st_nxt.rd_pend = 1'b0;
      st_nxt.ch = '{1'b1, TFQ_K_DATA, mem_rdata};
    end

    if (!selftest) begin
      st_nxt.lfsr = TFQ_LFSR_SEED;
      st_nxt.st_cnt = '0;
    end

    // One character decision per slot, self-test first
    if (slot) begin
      st_nxt.char_tgl = ~st_r.char_tgl;
      if (selftest) begin
        st_nxt.ch = '{1'b1, TFQ_K_SELFTEST, {1'b0, st_r.lfsr}};
        st_nxt.lfsr = {st_r.lfsr[7:0],
                       st_r.lfsr[8] ^ st_r.lfsr[TFQ_LFSR_TAP]};
        if (st_r.st_cnt == TFQ_ST_LAST) begin
          st_nxt.st_cnt = '0;
          st_nxt.seq_end = 1'b1;
        end else begin
          st_nxt.st_cnt = st_r.st_cnt + 9'h001;
        end
      end else if (st_r.halt) begin
        st_nxt.ch = '{1'b1, TFQ_K_FILL, TFQ_FILL_CHAR};
      end else if (bypassed) begin
        if (st_r.hold_v) begin
          st_nxt.ch = '{1'b1, TFQ_K_DATA, st_r.hold_w};
          st_nxt.hold_v = 1'b0;
        end else begin
          st_nxt.ch = '{1'b1, TFQ_K_FILL, TFQ_FILL_CHAR};
        end
      end else if (level != '0 && !in_reset && !st_r.rd_pend) begin
        // Reads never happen under self-test or halt
        rd_issue = 1'b1;
        st_nxt.rptr = st_r.rptr + 1'b1;
        st_nxt.rd_pend = 1'b1;
      end else begin
        st_nxt.ch = '{1'b1, TFQ_K_FILL, TFQ_FILL_CHAR};
      end
    end

    // Full flag source depends on bypass and rate
    if (bypassed) begin
      full_act = fast ? st_r.char_tgl : st_r.hold_v;
      if (ref_rise) begin
        st_nxt.full_pin = mode_hi ? full_act : ~full_act;
      end
    end else begin
      full_act = in_reset | near_full;
      st_nxt.full_pin = mode_hi ? full_act : ~full_act;
    end

    // Flag is driven only while chip select was sampled low
    if (host_edge) begin
      st_nxt.full_oe = ~st_r.s2.chip_select_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; pins reset to their idle pulled-up level
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.s1 <= '1;
      st_r.s2 <= '1;
      st_r.tclk_d <= 1'b1;
      st_r.rclk_d <= 1'b1;
      st_r.rst_st <= TFQ_RUN;
      st_r.lfsr <= TFQ_LFSR_SEED;
      st_r.ch.kind <= TFQ_K_FILL;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue storage
  tfq_mem #(
    .W(TFQ_DATA_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .rst(rst),
    .we(mem_we),
    .waddr(st_r.wptr[AW-1:0]),
    .wdata(wr_word),
    .raddr(st_r.rptr[AW-1:0]),
    .rdata(mem_rdata)
  );

  assign tx_queue_full_flag = st_r.full_pin;
  assign tx_queue_full_flag_oe = st_r.full_oe;
  assign tx_char = st_r.ch;
  assign selftest_loop_end = st_r.seq_end;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_low_capture: assert property (@(posedge clk) disable iff (rst)
    host_edge && !mode_hi && wen_act && st_r.sel_prev && !bypassed
    && room && !in_reset && st_nxt.rst_st == TFQ_RUN |-> mem_we)
    else $error("mode low write not captured");

  a_high_delay: assert property (@(posedge clk) disable iff (rst)
    host_edge && mode_hi && wen_act && st_r.sel_prev && !bypassed
    |=> st_r.pend ##0 !mem_we [*1])
    else $error("mode high write not deferred");

  a_no_select: assert property (@(posedge clk) disable iff (rst)
    host_edge && !st_r.sel_prev && !st_r.pend |-> !mem_we)
    else $error("write taken without selection");

  a_reset_start: assert property (@(posedge clk) disable iff (rst)
    tx_rise && rst_cond && st_r.rcnt == 3'h6 && !in_reset
    |=> st_r.rst_st == TFQ_RST_HOST ##1 st_r.wptr == '0)
    else $error("queue reset did not start on seventh sample");

  a_count_drop: assert property (@(posedge clk) disable iff (rst)
    tx_rise && !rst_cond |=> st_r.rcnt == '0)
    else $error("reset sample count not restarted");

  a_reset_full: assert property (@(posedge clk) disable iff (rst)
    in_reset && !bypassed |=> st_r.full_pin == $past(mode_hi))
    else $error("full not asserted during queue reset");

  a_reset_hold: assert property (@(posedge clk) disable iff (rst)
    st_r.rst_st == TFQ_RST_HOLD && !st_r.s2.tx_queue_reset_req
    |=> st_r.rst_st == TFQ_RST_HOLD)
    else $error("queue left reset while request held");

  a_bypass_rst: assert property (@(posedge clk) disable iff (rst)
    !in_reset && bypassed |=> !in_reset)
    else $error("reset started while bypassed");

  a_near_full: assert property (@(posedge clk) disable iff (rst)
    !bypassed && near_full |=> st_r.full_pin == $past(mode_hi))
    else $error("full not asserted near capacity");

  a_selftest_out: assert property (@(posedge clk) disable iff (rst)
    slot && selftest |=> st_r.ch.valid && st_r.ch.kind == TFQ_K_SELFTEST)
    else $error("self-test character missing");

  a_selftest_rd: assert property (@(posedge clk) disable iff (rst)
    selftest |-> !rd_issue)
    else $error("queue read during self-test");

  a_halt_fill: assert property (@(posedge clk) disable iff (rst)
    slot && st_r.halt && !selftest
    |=> st_r.ch.valid && st_r.ch.kind == TFQ_K_FILL)
    else $error("halt did not send fill");

  a_fast_toggle: assert property (@(posedge clk) disable iff (rst)
    slot && bypassed && fast |=> st_r.char_tgl != $past(st_r.char_tgl))
    else $error("full toggle missed a character");

  c_reset_seq: cover property (@(posedge clk) disable iff (rst)
    st_r.rst_st == TFQ_RST_HOLD ##1 st_r.rst_st == TFQ_RUN);
  c_loop_end: cover property (@(posedge clk) disable iff (rst)
    st_r.seq_end);
  c_bypass_write: cover property (@(posedge clk) disable iff (rst)
    bypassed && wr_req && !st_r.hold_v);
  c_near_full: cover property (@(posedge clk) disable iff (rst)
    !bypassed && near_full && mem_we);

endmodule // tfq_ctrl
`default_nettype wire

// file: src/tfq_mem.sv
// Queue storage: one write port, one read port with registered read data
`timescale 1ns/10ps
`default_nettype none
module tfq_mem #(
  parameter int W = 10,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  // Storage itself has no reset, only the read register does
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data always one cycle after the address
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // tfq_mem
`default_nettype wire

// file: src/tfq_pkg.sv
// Shared constants and types for the transmit queue write control block
package tfq_pkg;

  // Queue geometry
  localparam int TFQ_DATA_W = 10;
  localparam int TFQ_DEPTH = 256;

  // Reset request must be seen on this many queue clock edges in a row
  localparam int TFQ_RST_SAMPLES = 7;
  localparam logic [2:0] TFQ_RST_CNT_MAX = 3'h7;

  // Full flag asserts once this few free places or fewer remain
  localparam int TFQ_FULL_MARGIN = 4;

  // Self-test pattern: 9-bit maximal sequence, 511 characters long
  localparam int TFQ_ST_LEN = 511;
  localparam logic [8:0] TFQ_ST_LAST = 9'h1FE;
  localparam logic [8:0] TFQ_LFSR_SEED = 9'h1FF;
  localparam int TFQ_LFSR_TAP = 4;

  // Idle fill character sent while halted or starved
  localparam logic [TFQ_DATA_W-1:0] TFQ_FILL_CHAR = 10'h155;

  // Kind of character handed to the serial side
  typedef enum logic [1:0] {
    TFQ_K_DATA,
    TFQ_K_FILL,
    TFQ_K_SELFTEST
  } tfq_kind_t;

  // Reset sequencing state
  typedef enum logic [1:0] {
    TFQ_RUN,
    TFQ_RST_HOST,
    TFQ_RST_SERIAL,
    TFQ_RST_HOLD
  } tfq_rst_t;

  // All pins of the host side, sampled as one bundle
  typedef struct packed {
    logic tx_queue_clock;
    logic reference_clock;
    logic chip_select_n;
    logic tx_write_enable;
    logic external_queue_mode_sel;
    logic tx_selftest_enable_n;
    logic tx_queue_reset_req;
    logic tx_suspend_n;
    logic queue_bypass_sel;
    logic freq_range_sel;
    logic speed_sel;
    logic [TFQ_DATA_W-1:0] tx_parallel_word;
  } tfq_pins_t;

  // Character toward the encoder
  typedef struct packed {
    logic valid;
    tfq_kind_t kind;
    logic [TFQ_DATA_W-1:0] word;
  } tfq_char_t;

endpackage

// file: tb/testbench.sv
// Self-checking bench for the transmit queue write control block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import tfq_pkg::*;
;
  localparam int DEPTH = 16;
  logic clk, rst, ref_clk, mode, st_n, rst_req, susp_n, byp_sel;
  logic range_sel, spd_sel, tq_clk, cs_n, wen, full, full_oe, loop_end;
  logic full_d;
  logic [TFQ_DATA_W-1:0] word;
  tfq_char_t tx_char;
  int n_fail, checks, cyc, n_st, st_last, loop_len, n_le, n_tog, k;
  logic [TFQ_DATA_W-1:0] exp_q[$], got[$], st_q[$];

  tfq_host_model i_host (
    .mode(mode),
    .tx_queue_clock(tq_clk),
    .chip_select_n(cs_n),
    .tx_write_enable(wen),
    .tx_parallel_word(word)
  );

  tfq_ctrl #(.DEPTH(DEPTH)) i_dut (
    .clk(clk),
    .rst(rst),
    .tx_queue_clock(tq_clk),
    .reference_clock(ref_clk),
    .chip_select_n(cs_n),
    .tx_write_enable(wen),
    .external_queue_mode_sel(mode),
    .tx_selftest_enable_n(st_n),
    .tx_queue_reset_req(rst_req),
    .tx_suspend_n(susp_n),
    .queue_bypass_sel(byp_sel),
    .freq_range_sel(range_sel),
    .speed_sel(spd_sel),
    .tx_parallel_word(word),
    .tx_queue_full_flag(full),
    .tx_queue_full_flag_oe(full_oe),
    .tx_char(tx_char),
    .selftest_loop_end(loop_end)
  );

  // System clock, 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reference clock, phase unrelated to the system clock
  initial begin
    ref_clk = 1'b0;
    #3.3;
    forever #20 ref_clk = ~ref_clk;
  end

  // Pin level of an active-level signal under the current mode
  function automatic logic pin_lvl(input logic a);
    return a ~^ mode;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Mid-period after the n-th queue clock rise, clear of the sync window
  task automatic wait_tx(input int n);
    repeat (n) @(posedge tq_clk);
    ticks(16);
  endtask

  task automatic send(input logic sel, input int n);
    logic [TFQ_DATA_W-1:0] w;
    for (int i = 0; i < n; i++) begin
      w = TFQ_DATA_W'($urandom);
      i_host.wq.push_back(w);
      if (sel) exp_q.push_back(w);
    end
    i_host.burst(sel, n);
    ticks(40);
  endtask

  // Deselect around a mode change so the old idle level is not a write
  task automatic set_mode(input logic m);
    i_host.burst(1'b0, 0);
    mode = m;
    i_host.burst(1'b0, 0);
  endtask

  task automatic drain();
    k = 0;
    while (got.size() < exp_q.size() && k < 4000) begin
      ticks(1);
      k++;
    end
    check("data_count", got.size(), exp_q.size());
    while (got.size() > 0 && exp_q.size() > 0) begin
      check("data_word", got.pop_front(), exp_q.pop_front());
    end
    exp_q.delete();
    got.delete();
  endtask

  // Collects data characters, self-test counts and flag toggles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    full_d <= full;
    if (full !== full_d) n_tog++;
    if (tx_char.valid === 1'b1 && tx_char.kind === TFQ_K_DATA) begin
      got.push_back(tx_char.word);
    end
    // Sequence must repeat exactly every loop length
    if (tx_char.valid === 1'b1 && tx_char.kind === TFQ_K_SELFTEST) begin
      n_st++;
      st_q.push_back(tx_char.word);
      if (st_q.size() > TFQ_ST_LEN) begin
        check("st_repeat", tx_char.word, st_q.pop_front());
      end
    end
    if (loop_end === 1'b1) begin
      loop_len = n_st - st_last;
      st_last = n_st;
      n_le++;
    end
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    rst = 1'b1;
    mode = 1'b1;
    st_n = 1'b1;
    rst_req = 1'b1;
    susp_n = 1'b0;
    byp_sel = 1'b1;
    range_sel = 1'b0;
    spd_sel = 1'b1;
    void'($urandom(98));
    ticks(20);
    rst = 1'b0;
    ticks(4);
    // Halted: writes still land, nothing read, flag at the margin
    send(1'b1, DEPTH - TFQ_FULL_MARGIN - 1);
    check("full_below", full, pin_lvl(1'b0));
    check("flag_oe", full_oe, 1'b1);
    check("halt_reads", got.size(), 0);
    send(1'b1, 1);
    check("full_at", full, pin_lvl(1'b1));
    susp_n = 1'b1;
    drain();
    check("full_free", full, pin_lvl(1'b0));
    // Random bursts in both enable polarities, then an unselected one
    for (int m = 0; m < 2; m++) begin
      set_mode(m[0]);
      send(1'b1, 1 + $urandom_range(5));
      drain();
      check("full_pol", full, pin_lvl(1'b0));
      send(1'b0, 3);
      check("flag_off", full_oe, 1'b0);
      drain();
    end
    // Self-test overrides halt and leaves queued words in place
    susp_n = 1'b0;
    send(1'b1, 3);
    st_n = 1'b0;
    k = 0;
    while (n_le < 2 && k < 10000) begin
      ticks(1);
      k++;
    end
    check("st_len", loop_len, TFQ_ST_LEN);
    check("st_reads", got.size(), 0);
    st_n = 1'b1;
    susp_n = 1'b1;
    drain();
    // Queue reset: count restarts on a gap, starts on the seventh
    susp_n = 1'b0;
    send(1'b1, 5);
    exp_q.delete();
    rst_req = 1'b0;
    wait_tx(6);
    check("rst_six", full, pin_lvl(1'b0));
    rst_req = 1'b1;
    wait_tx(1);
    rst_req = 1'b0;
    wait_tx(6);
    check("rst_restart", full, pin_lvl(1'b0));
    wait_tx(1);
    check("rst_seven", full, pin_lvl(1'b1));
    wait_tx(10);
    check("rst_hold", full, pin_lvl(1'b1));
    rst_req = 1'b1;
    wait_tx(3);
    check("rst_done", full, pin_lvl(1'b0));
    susp_n = 1'b1;
    ticks(100);
    check("rst_cleared", got.size(), 0);
    // Bypassed: reset request ignored, idle not busy, fast rate toggles
    byp_sel = 1'b0;
    rst_req = 1'b0;
    wait_tx(10);
    check("byp_rst", full, pin_lvl(1'b0));
    rst_req = 1'b1;
    range_sel = 1'b1;
    repeat (4) @(posedge ref_clk);
    n_tog = 0;
    repeat (40) @(posedge ref_clk);
    check("byp_toggle", n_tog inside {[19:21]}, 1'b1);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire

// file: tb/tfq_host_model.sv
// Host writer model: makes the queue clock and drives write cycles
`timescale 1ns/10ps
`default_nettype none
module tfq_host_model
  import tfq_pkg::*;
(
  input wire logic mode,
  output logic tx_queue_clock,
  output logic chip_select_n,
  output logic tx_write_enable,
  output logic [TFQ_DATA_W-1:0] tx_parallel_word
);
  logic [TFQ_DATA_W-1:0] wq[$];

  // Free-running queue clock, kept going so halt and reset samples are seen
  initial begin
    tx_queue_clock = 1'b0;
    chip_select_n = 1'b1;
    tx_write_enable = 1'b0;
    tx_parallel_word = '0;
    forever #80 tx_queue_clock = ~tx_queue_clock;
  end

  // Chip select leads the enable by one edge; mode 1 data lags by one
  task automatic burst(input logic sel, input int n);
    int idx;
    for (int s = 0; s <= n + 2; s++) begin
      // Change mid-period so the pins stand still at every rising edge
      @(negedge tx_queue_clock);
      idx = mode ? s - 2 : s - 1;
      chip_select_n = !sel;
      tx_write_enable = (s >= 1 && s <= n) ? mode : !mode;
      if (idx >= 0 && idx < n) begin
        tx_parallel_word = wq[idx];
      end else begin
        tx_parallel_word = ~tx_parallel_word;
      end
    end
    wq.delete();
  endtask
endmodule // tfq_host_model
`default_nettype wire
